// ==== src/arsc_map.svh ====
`ifndef ARSC_MAP_SVH
`define ARSC_MAP_SVH
// special-function-register addresses
`define ARSC_ADDR_OFFSET_LOW 8'h85
`define ARSC_ADDR_OFFSET_HIGH 8'h86
`define ARSC_ADDR_REF_CTRL 8'hD1
// reference control field positions
`define ARSC_BIT_GND_SEL 5
`define ARSC_BIT_REF_SEL_HI 4
`define ARSC_BIT_REF_SEL_LO 3
`define ARSC_BIT_SENSOR_EN 2
`define ARSC_BIT_PREC_OE 0
// reset values
`define ARSC_RST_REF_CTRL 8'h18
// arbitrary default offset, normally set by production trim
`define ARSC_DEF_SENSOR_OFFSET 10'h200
`endif

// ==== src/arsc_mux_ctrl.sv ====
`timescale 1ns/100ps
// combinational steering of reference and ground multiplexers
module arsc_mux_ctrl (
   // software settings
   input arsc_pkg::arsc_ctrl_type ctrl,
   // converter phase
   input arsc_pkg::arsc_phase_type phase,
   input wire logic sensor_selected,
   // analog controls before registering
   output arsc_pkg::arsc_analog_type analog
);
   // per-phase ground choice
   function automatic logic gnd_pick(input arsc_pkg::arsc_ctrl_type c, input arsc_pkg::arsc_phase_type p,
                                     input logic sens);
      logic g;
      g = c.analog_ground_select;
      if (p == arsc_pkg::ARSC_PH_SAMPLE && sens) begin
         g = 1'b0;
      end
      if (p == arsc_pkg::ARSC_PH_CONVERT && c.reference_select == arsc_pkg::ARSC_REF_HIGH_SPEED) begin
         g = 1'b0;
      end
      return g;
   endfunction : gnd_pick

   // reference and enable decode
   always_comb begin
      analog.ref_mux_sel = ctrl.reference_select;
      analog.gnd_from_pin = gnd_pick(ctrl, phase, sensor_selected);
      // high-speed reference only powered while the converter works, low power otherwise
      analog.high_speed_ref_en = (ctrl.reference_select == arsc_pkg::ARSC_REF_HIGH_SPEED)
                                 && (phase != arsc_pkg::ARSC_PH_IDLE);
      analog.precision_ref_en = ctrl.precision_reference_output_enable;
      analog.precision_ref_to_pin = ctrl.precision_reference_output_enable;
      analog.sensor_on = ctrl.sensor_enable;
   end
endmodule : arsc_mux_ctrl

// ==== src/arsc_pkg.sv ====
package arsc_pkg;
   // reference multiplexer codes
   typedef enum logic [1:0] {
      ARSC_REF_EXT_PIN = 2'h0,
      ARSC_REF_MAIN_SUPPLY = 2'h1,
      ARSC_REF_DIGITAL_SUPPLY = 2'h2,
      ARSC_REF_HIGH_SPEED = 2'h3
   } arsc_ref_sel_type;
   // software-visible control fields
   typedef struct packed {
      logic analog_ground_select;
      arsc_ref_sel_type reference_select;
      logic sensor_enable;
      logic precision_reference_output_enable;
   } arsc_ctrl_type;
   // converter phase indications
   typedef struct packed {
      logic sampling;
      logic converting;
      logic sensor_selected;
   } arsc_conv_type;
   // analog-side controls
   typedef struct packed {
      arsc_ref_sel_type ref_mux_sel;
      logic gnd_from_pin;
      logic high_speed_ref_en;
      logic precision_ref_en;
      logic precision_ref_to_pin;
      logic sensor_on;
   } arsc_analog_type;
   // phase of the converter as seen by the ground mux
   typedef enum logic [2:0] {
      ARSC_PH_IDLE = 3'h1,
      ARSC_PH_SAMPLE = 3'h2,
      ARSC_PH_CONVERT = 3'h4
   } arsc_phase_type;
endpackage : arsc_pkg

// ==== src/arsc_top.sv ====
// Operation
// - the high offset byte reads offset bits 9:2, read only, with a part-specific value.
// - the low offset byte holds offset bits 1:0 in bits 7:6, bits 5:0 read zero, writes ignored.
// - select code 00 with precision enable clear routes the external pin and keeps precision off.
// - select code 11 powers the high-speed reference only while the converter is working.
// - precision enable 1 with code 00 turns the precision reference on and uses it.
// - code 01 selects the main supply and code 10 the internal digital supply.
// - ground select 1 takes ground from the analog ground pin in sampling and conversion.
// - sampling the temperature sensor always uses internal ground.
// - with the high-speed reference selected, conversion always uses internal ground.
// - the sensor enable bit switches the sensor; off leaves its output high impedance.
// - the offset bytes hold a production raw result taken near room temperature.
// - control holds ground select bit 5, select bits 4:3, sensor enable bit 2, output enable bit 0.
`timescale 1ns/100ps
`include "arsc_map.svh"
module arsc_top #(
   // production trim value, arbitrary default
   parameter logic [9:0] SENSOR_OFFSET = `ARSC_DEF_SENSOR_OFFSET
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // special-function-register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // converter status
   input arsc_pkg::arsc_conv_type conv,
   // analog controls
   output arsc_pkg::arsc_analog_type analog
);
   logic rst_meta_r;
   logic rst_sync_r;
   arsc_pkg::arsc_ctrl_type ctrl_r;
   arsc_pkg::arsc_ctrl_type ctrl_nxt;
   arsc_pkg::arsc_phase_type phase_r;
   arsc_pkg::arsc_phase_type phase_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   arsc_pkg::arsc_analog_type analog_r;
   arsc_pkg::arsc_analog_type analog_comb;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // control register pack and unpack
   function automatic logic [7:0] ctrl_pack(input arsc_pkg::arsc_ctrl_type c);
      logic [7:0] v;
      v = 8'h00; // unused bits 7:6 and 1 read zero
      v[`ARSC_BIT_GND_SEL] = c.analog_ground_select;
      v[`ARSC_BIT_REF_SEL_HI:`ARSC_BIT_REF_SEL_LO] = c.reference_select;
      v[`ARSC_BIT_SENSOR_EN] = c.sensor_enable;
      v[`ARSC_BIT_PREC_OE] = c.precision_reference_output_enable;
      return v;
   endfunction : ctrl_pack

   function automatic arsc_pkg::arsc_ctrl_type ctrl_unpack(input logic [7:0] v);
      arsc_pkg::arsc_ctrl_type c;
      c.analog_ground_select = v[`ARSC_BIT_GND_SEL];
      c.reference_select = arsc_pkg::arsc_ref_sel_type'(v[`ARSC_BIT_REF_SEL_HI:`ARSC_BIT_REF_SEL_LO]);
      c.sensor_enable = v[`ARSC_BIT_SENSOR_EN];
      c.precision_reference_output_enable = v[`ARSC_BIT_PREC_OE];
      return c;
   endfunction : ctrl_unpack

   // register writes; offset bytes take no write
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (sfr_wr && sfr_addr == `ARSC_ADDR_REF_CTRL) begin
         ctrl_nxt = ctrl_unpack(sfr_wdata);
      end
   end

   // converter phase tracking, conversion outranks sampling
   always_comb begin
      if (conv.converting) begin
         phase_nxt = arsc_pkg::ARSC_PH_CONVERT;
      end else if (conv.sampling) begin
         phase_nxt = arsc_pkg::ARSC_PH_SAMPLE;
      end else begin
         phase_nxt = arsc_pkg::ARSC_PH_IDLE;
      end
   end

   // read data, unmapped addresses read zero
   always_comb begin
      rdata_nxt = sfr_rdata;
      if (sfr_rd) begin
         unique case (sfr_addr)
            `ARSC_ADDR_OFFSET_HIGH: rdata_nxt = SENSOR_OFFSET[9:2];
            `ARSC_ADDR_OFFSET_LOW: rdata_nxt = {SENSOR_OFFSET[1:0], 6'h00};
            `ARSC_ADDR_REF_CTRL: rdata_nxt = ctrl_pack(ctrl_r);
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // steering uses the registered settings, so outputs lag a write by one edge
   arsc_mux_ctrl u_mux (
      .ctrl(ctrl_r),
      .phase(phase_nxt),
      .sensor_selected(conv.sensor_selected),
      .analog(analog_comb)
   );

   // state registers, frozen while clk_en low
   always_ff @(posedge core_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_r <= ctrl_unpack(`ARSC_RST_REF_CTRL);
         phase_r <= arsc_pkg::ARSC_PH_IDLE;
         rdata_r <= 8'h00;
         analog_r <= '0;
      end else if (clk_en) begin
         ctrl_r <= ctrl_nxt;
         phase_r <= phase_nxt;
         rdata_r <= rdata_nxt;
         analog_r <= analog_comb;
      end
   end

   assign sfr_rdata = rdata_r;
   assign analog = analog_r;
endmodule : arsc_top

// ==== tb/arsc_conv_model.sv ====
`timescale 1ns/100ps
module arsc_conv_model (
   // clock
   input wire logic core_clk,
   // phase request: 0 idle, 1 sample, 2 convert
   input wire logic [1:0] req,
   input wire logic sens,
   // status toward the block
   output arsc_pkg::arsc_conv_type conv
);
   // phases never overlap, as a real sequencer keeps them apart
   always_ff @(posedge core_clk) begin
      conv.sampling <= req == 2'h1;
      conv.converting <= req == 2'h2;
      conv.sensor_selected <= sens;
   end
endmodule : arsc_conv_model

// ==== tb/arsc_top_bench.sv ====
`timescale 1ns/100ps
module arsc_top_bench;
   localparam logic [9:0] OFF = 10'h2B7;
   `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
      $display("[ERR] %s exp %h got %h", n, e, g); end end
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [1:0] req = 2'h0;
   logic sens = 1'b0;
   arsc_pkg::arsc_conv_type conv;
   arsc_pkg::arsc_analog_type analog;
   int err_total = 0;
   int samples_checked = 0;
   always #5 core_clk = ~core_clk;
   arsc_top #(.SENSOR_OFFSET(OFF)) arsc_top_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .conv(conv), .analog(analog));
   arsc_conv_model arsc_conv_model_inst (.core_clk(core_clk), .req(req), .sens(sens), .conv(conv));
   // one access; writes wait two edges more so the analog side has followed
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      sfr_addr = a;
      sfr_wr = w;
      sfr_rd = !w;
      sfr_wdata = d;
      @(posedge core_clk);
      #1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      if (w) begin
         repeat (2) @(posedge core_clk);
         #1;
      end
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK("read data", e, sfr_rdata)
   endtask : rd
   // phase request, judged once status and ground logic have both moved
   task automatic ph(input logic [1:0] r, input logic s, input logic eg, input logic eh);
      @(posedge core_clk);
      #1;
      req = r;
      sens = s;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("ground from pin", eg, analog.gnd_from_pin)
      `CHK("high-speed enable", eh, analog.high_speed_ref_en)
   endtask : ph
   task automatic t_regs;
      rd(8'hD1, 8'h18);
      `CHK("reset select", 2'h3, analog.ref_mux_sel)
      acc(1'b1, 8'h86, 8'h00);
      acc(1'b1, 8'h85, 8'hFF);
      rd(8'h86, OFF[9:2]);
      rd(8'h85, {OFF[1:0], 6'h00});
      rd(8'h40, 8'h00);
      $display("regs test done");
   endtask : t_regs
   // every select code, precision enable both ways, reserved bits written as ones
   task automatic t_sel;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {2'h3, 1'b0, i[1:0], i[0], 1'b1, i[2]};
         acc(1'b1, 8'hD1, d);
         rd(8'hD1, d & 8'h3D);
         `CHK("reference select", i[1:0], analog.ref_mux_sel)
         `CHK("precision enable", i[2], analog.precision_ref_en)
         `CHK("precision to pin", i[2], analog.precision_ref_to_pin)
         `CHK("sensor on", i[0], analog.sensor_on)
      end
      $display("select test done");
   endtask : t_sel
   task automatic t_gnd;
      acc(1'b1, 8'hD1, 8'h38);
      ph(2'h0, 1'b0, 1'b1, 1'b0);
      ph(2'h1, 1'b0, 1'b1, 1'b1);
      ph(2'h2, 1'b0, 1'b0, 1'b1);
      ph(2'h1, 1'b1, 1'b0, 1'b1);
      acc(1'b1, 8'hD1, 8'h20);
      ph(2'h2, 1'b0, 1'b1, 1'b0);
      ph(2'h1, 1'b1, 1'b0, 1'b0);
      $display("ground test done");
   endtask : t_gnd
   // write while frozen must be lost, then a reset in mid-run restores defaults
   task automatic t_freeze;
      @(posedge core_clk);
      #1;
      clk_en = 1'b0;
      acc(1'b1, 8'hD1, 8'h01);
      clk_en = 1'b1;
      `CHK("frozen select", 2'h0, analog.ref_mux_sel)
      rd(8'hD1, 8'h20);
      resetn = 1'b0;
      @(posedge core_clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      rd(8'hD1, 8'h18);
      `CHK("select after reset", 2'h3, analog.ref_mux_sel)
      $display("freeze test done");
   endtask : t_freeze
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // hang guard
   initial begin
      #100000;
      err_total++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs();
      t_sel();
      t_gnd();
      t_freeze();
      wrap_up();
   end
endmodule : arsc_top_bench

// ==== tb/arsc_top_chk.sv ====
`timescale 1ns/100ps
module arsc_top_chk #(
   parameter logic [9:0] SENSOR_OFFSET = 10'h200
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // converter and analog side
   input arsc_pkg::arsc_conv_type conv,
   input arsc_pkg::arsc_analog_type analog
);
   // outputs lag the synchronised release, so checks wait four running edges
   logic [2:0] up_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) up_r <= 3'h0;
      else if (!clk_en) up_r <= 3'h0;
      else if (up_r != 3'h4) up_r <= up_r + 3'h1;
   end
   wire ok = up_r == 3'h4 && clk_en;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   hs_ref_a: assert property (ok |-> analog.high_speed_ref_en == (analog.ref_mux_sel == 2'h3 &&
      $past(conv.sampling || conv.converting))) else $error("high-speed enable wrong");
   gnd_conv_a: assert property (ok && $past(conv.converting) && analog.ref_mux_sel == 2'h3
      |-> !analog.gnd_from_pin) else $error("conversion ground not internal");
   gnd_sens_a: assert property (ok && $past(conv.sampling && !conv.converting && conv.sensor_selected)
      |-> !analog.gnd_from_pin) else $error("sensor sampling ground not internal");
   prec_pin_a: assert property (ok |-> analog.precision_ref_en == analog.precision_ref_to_pin)
      else $error("precision enable and pin disagree");
   read_high_a: assert property (ok && $past(sfr_rd && sfr_addr == 8'h86) |->
      sfr_rdata == SENSOR_OFFSET[9:2]) else $error("high offset byte wrong");
   read_low_a: assert property (ok && $past(sfr_rd && sfr_addr == 8'h85) |->
      sfr_rdata == {SENSOR_OFFSET[1:0], 6'h00}) else $error("low offset byte wrong");
   ctrl_read_a: assert property (ok && $past(sfr_rd && sfr_addr == 8'hD1) |->
      sfr_rdata[7:6] == 2'h0 && !sfr_rdata[1]) else $error("unused control bits not zero");
   rdata_hold_a: assert property (ok && !$past(sfr_rd) |-> $stable(sfr_rdata))
      else $error("read data changed without read");
   sel_write_a: assert property (ok && $past(sfr_wr && sfr_addr == 8'hD1, 2) |->
      analog.ref_mux_sel == $past(sfr_wdata[4:3], 2)) else $error("select not updated");
   sens_write_a: assert property (ok && $past(sfr_wr && sfr_addr == 8'hD1, 2) |->
      analog.sensor_on == $past(sfr_wdata[2], 2)) else $error("sensor enable not updated");
   cover property (sfr_wr && sfr_addr == 8'hD1);
   cover property (conv.converting && analog.ref_mux_sel == 2'h3);
   cover property (conv.sampling && conv.sensor_selected);
endmodule : arsc_top_chk
bind arsc_top arsc_top_chk #(.SENSOR_OFFSET(SENSOR_OFFSET)) arsc_top_chk_inst (.core_clk(core_clk),
   .resetn(resetn), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv(conv), .analog(analog));
